// ### bench/sar_host.sv
// Host model: drives select and read clock and reads the serial word.
// Assumes the bench feeds back the resolved data pin.
`timescale 1ns/10ps
module sar_host (
  input wire logic mclk,
  input wire logic busy,
  input wire logic sdoPin,
  output logic convSelectN,
  output logic sck
);
  initial begin
    convSelectN = 1'b1;
    sck = 1'b0;
  end
  task automatic frame(input int n, input int hiNs, output logic [19:0] bits, output bit tmo);
    int k;
    k = 0;
    bits = '0;
    @(posedge mclk);
    #(hiNs + 3) convSelectN = 1'b0;
    while (busy !== 1'b1 && k < 20) begin
      @(posedge mclk);
      #1 k++;
    end
    tmo = busy !== 1'b1;
    // read clock held low in conversion
    while (busy === 1'b1 && k < 300) begin
      @(posedge mclk);
      #1 k++;
    end
    tmo = tmo || busy !== 1'b0;
    bits[19] = sdoPin;
    // slow read clock, frame stretched for extra bits
    for (int i = 1; i <= n; i++) begin
      #62.5 sck = 1'b1;
      #62.5 sck = 1'b0;
      if (i < 20) bits[19-i] = sdoPin;
    end
    #62.5 convSelectN = 1'b1;
  endtask
endmodule

// ### bench/sar_props.sv
// Checker on the readout block ports, attached by bind.
// Assumes the bench shortens the conversion counts through the parameters.
`timescale 1ns/10ps
module sar_props #(
  parameter int ConvCount = 8,
  parameter int ConvBypassCount = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic convSelectN,
  input wire logic sck,
  input wire logic powerdownPin,
  input wire logic busy,
  input wire logic sdoOut,
  input wire logic sdoOutEnN,
  input wire logic idlePartialPowerdown,
  input wire logic wordValid
);
  int busyCnt;
  always_ff @(posedge mclk) begin
    busyCnt <= (rst || !busy) ? 0 : busyCnt + 1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  busy_len_a: assert property (
    $fell(busy) |-> busyCnt == ConvCount || busyCnt == ConvBypassCount) else $error("Busy length.");
  busy_start_a: assert property (
    $fell(convSelectN) && sdoOutEnN && !busy && !powerdownPin |-> ##[2:5] busy) else $error("No start.");
  conv_drive_a: assert property (
    busy |-> !sdoOutEnN && !sdoOut) else $error("Data not low in conversion.");
  nap_set_a: assert property (
    $fell(busy) |-> idlePartialPowerdown && !sdoOutEnN) else $error("No nap after conversion.");
  nap_hold_a: assert property (
    (!convSelectN)[*4] ##0 idlePartialPowerdown |=> idlePartialPowerdown) else $error("Nap left.");
  out_hiz_a: assert property (
    convSelectN[*5] |-> sdoOutEnN) else $error("Data driven while deselected.");
  sdo_hold_a: assert property (
    (!convSelectN && !busy && $stable(sck))[*5] |=> $stable(sdoOut)) else $error("Data moved.");
  word_push_a: assert property (
    $fell(busy) |-> ##[1:3] wordValid) else $error("Word not buffered.");
  cover property ($fell(busy));
  cover property (idlePartialPowerdown && convSelectN);
  cover property (wordValid && busy);
endmodule
bind sar_adc_serial_readout sar_props #(.ConvCount(ConvCount), .ConvBypassCount(ConvBypassCount))
  chk_u (.mclk(mclk), .rst(rst), .convSelectN(convSelectN), .sck(sck), .powerdownPin(powerdownPin),
  .busy(busy), .sdoOut(sdoOut), .sdoOutEnN(sdoOutEnN),
  .idlePartialPowerdown(idlePartialPowerdown), .wordValid(wordValid));

// ### bench/tb_top.sv
// Bench: host model frames, expected words queued and compared on pop.
// Assumes conversion counts shortened to 8 and 4 cycles.
`timescale 1ns/10ps
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] chanSel = 3'h0;
  logic [2:0] gainSel = 3'h0;
  logic reducedPowerPin = 1'b0;
  logic powerdownPin = 1'b0;
  logic [13:0] sampleCode = 14'h0000;
  logic wordReady = 1'b0;
  logic rdyOn = 1'b1;
  logic busy, sdoOut, sdoOutEnN, idle_partial_powerdown, sampleInvalid, wordValid, wordOverrun, convSelectN, sck;
  logic [20:0] wordData;
  wire sdoPin = sdoOutEnN ? 1'bz : sdoOut;
  logic [20:0] expQ[$];
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 32'hF369762C;
  bit first = 1'b1;
  logic [2:0] gLast = 3'h0;
  localparam int ConvLen = 8;
  localparam int BypassLen = 4;
  int busyLen = 0;
  int lastBusyLen = 0;
  always #5 mclk = ~mclk;
  sar_adc_serial_readout #(.ConvCount(ConvLen), .ConvBypassCount(BypassLen)) dut_u (
    .mclk(mclk), .rst(rst),
    .convSelectN(convSelectN), .sck(sck), .chanSel(chanSel), .gainSel(gainSel),
    .reducedPowerPin(reducedPowerPin), .powerdownPin(powerdownPin), .sampleCode(sampleCode),
    .busy(busy), .sdoOut(sdoOut), .sdoOutEnN(sdoOutEnN), .idlePartialPowerdown(idle_partial_powerdown),
    .sampleInvalid(sampleInvalid), .wordData(wordData), .wordValid(wordValid),
    .wordReady(wordReady), .wordOverrun(wordOverrun));
  sar_host host_u (.mclk(mclk), .busy(busy), .sdoPin(sdoPin), .convSelectN(convSelectN),
    .sck(sck));
  task automatic chk(input logic [20:0] seen, input logic [20:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Random stalls on the word side; a word due is always queued first.
  always @(posedge mclk) begin
    wordReady <= rdyOn & ($random(seed) % 2 != 0);
    if (wordValid && wordReady) begin
      chk(21'(expQ.size() != 0), 21'h1, "word due");
      if (expQ.size() != 0) chk(wordData, expQ.pop_front(), "word");
    end
  end
  // Length of the last busy pulse in clock cycles, for the gain bypass check.
  always @(posedge mclk) begin
    if (busy === 1'b1) begin
      busyLen <= busyLen + 1;
    end else if (busyLen != 0) begin
      lastBusyLen <= busyLen;
      busyLen <= 0;
    end
  end
  task automatic frame(input int n, input int hiNs, input bit keep);
    logic [20:0] w;
    logic [19:0] bits;
    bit tmo;
    int s;
    @(posedge mclk);
    chanSel <= 3'($random(seed));
    gainSel <= 3'($random(seed));
    sampleCode <= 14'($random(seed));
    @(posedge mclk);
    w = {first & ~reducedPowerPin, sampleCode, chanSel, reducedPowerPin ? gainSel : gLast};
    gLast = gainSel;
    first = 1'b0;
    s = 19 - (n > 19 ? 19 : n);
    // The word can be popped while the frame is still being read, so note it first.
    if (keep) expQ.push_back(w);
    host_u.frame(n, hiNs, bits, tmo);
    if (tmo) begin
      error_cnt++;
      wrap_up();
    end
    chk(21'(bits >> s), 21'(w[19:0] >> s), "serial");
    chk(21'(sampleInvalid), 21'(w[20]), "invalid flag");
    chk(21'(lastBusyLen), (w[2:0] == 3'h0) ? 21'(BypassLen) : 21'(ConvLen), "busy length");
  endtask
  task automatic drain();
    for (int k = 0; k < 300 && expQ.size() != 0; k++) @(posedge mclk);
    chk(21'(expQ.size()), 21'h0, "drained");
  endtask
  initial begin
    int ns[6] = '{19, 19, 19, 16, 13, 20};
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    foreach (ns[i]) frame(ns[i], 200, 1'b1);
    drain();
    $display("normal and short reads done");
    rdyOn <= 1'b0;
    for (int i = 0; i < 3; i++) frame(19, 200, i < 2);
    chk(21'(wordOverrun), 21'h1, "overrun");
    @(posedge mclk);
    rdyOn <= 1'b1;
    drain();
    $display("buffer full done");
    rst <= 1'b1;
    reducedPowerPin <= 1'b1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    first = 1'b1;
    chk(21'(wordOverrun), 21'h0, "overrun clear");
    for (int i = 0; i < 3; i++) frame(19, 600, 1'b1);
    $display("reduced mode done");
    powerdownPin <= 1'b1;
    reducedPowerPin <= 1'b0;
    repeat (20) @(posedge mclk);
    powerdownPin <= 1'b0;
    first = 1'b1;
    for (int i = 0; i < 2; i++) frame(19, 200, 1'b1);
    drain();
    $display("power-down exit done");
    wrap_up();
  end
endmodule

// ### core/sar_adc_serial_readout.sv
// Conversion sequencing and serial readout of a 14-bit converter with channel and gain report.
// Assumes select line and read clock come from a host on another clock; both are synchronised.
// Contract
// - Select falling edge samples selected channel and starts timed conversion.
// - Busy is high throughout conversion and drops when it completes.
// - Top result bit appears on data out as busy falls.
// - Each later rising read clock edge shifts next bit down to bottom bit.
// - Up to six extra edges shift out channel and gain report bits.
// - Report order: channel bits MSB first, then gain bits MSB first.
// - Fewer extra edges give only that many report bits.
// - Data out is high impedance while select is high.
// - Select falling edge enables data out driving low until result.
// - Phases run acquisition, conversion, readout; acquisition follows readout at select rise.
// - Idle nap after conversion until the next select rising edge.
// - Normal mode: first sample after power or power-down is invalid.
// - Gain and channel come from digital input pins, gain bypass included.
// - Gain latched at select rise; normal uses next conversion, reduced uses current.
// - Reduced power: acquisition lasts the select high time.
`timescale 1ns/10ps
module sar_adc_serial_readout #(
  parameter int ConvCount = sar_pkg::ConvCycles,
  parameter int ConvBypassCount = sar_pkg::ConvBypassCycles
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic convSelectN,
  input wire logic sck,
  input wire logic [2:0] chanSel,
  input wire logic [2:0] gainSel,
  input wire logic reducedPowerPin,
  input wire logic powerdownPin,
  input wire logic [13:0] sampleCode,
  output logic busy,
  output logic sdoOut,
  output logic sdoOutEnN,
  output logic idlePartialPowerdown,
  output logic sampleInvalid,
  output logic [20:0] wordData,
  output logic wordValid,
  input wire logic wordReady,
  output logic wordOverrun
);
  typedef struct packed {
    logic [1:0] selSync;
    logic [1:0] sckSync;
    logic [1:0] lpSync;
    logic [1:0] pdSync;
    logic [2:0] chanSync0;
    logic [2:0] chanSync1;
    logic [2:0] gainSync0;
    logic [2:0] gainSync1;
    logic [sar_pkg::ResultBits-1:0] sampleSync0;
    logic [sar_pkg::ResultBits-1:0] sampleSync1;
    logic selPrev;
    logic sckPrev;
    sar_pkg::sar_phase_e phase;
    logic [sar_pkg::CountWidth-1:0] convCnt;
    logic [sar_pkg::FrameBits-1:0] shiftReg;
    logic [sar_pkg::BitCountWidth-1:0] bitCnt;
    logic [2:0] gainLatched;
    logic needsWarm;
    logic curInvalid;
    logic busy;
    logic sdo;
    logic sdoEnN;
    logic idle_partial_powerdown;
    logic invalid;
    logic pushValid;
    logic [20:0] pushData;
    logic overrun;
  } sar_state_s;
  sar_state_s st_reg;
  sar_state_s st_next;
  logic selFall;
  logic selRise;
  logic sckRise;
  logic bufInReady;
  logic bufOutValid;
  logic [20:0] bufOutData;
  logic [2:0] gainForConv;
  logic [sar_pkg::CountWidth-1:0] convLimit;

  // Rising edge of a synchronised level; a falling edge is found from inverted levels.
  function automatic logic isRise(input logic prev, input logic cur);
    return !prev && cur;
  endfunction
  always_comb begin
    st_next = st_reg;
    st_next.selSync = {st_reg.selSync[0], convSelectN};
    st_next.sckSync = {st_reg.sckSync[0], sck};
    // Mode and power-down pins are treated as static between conversions.
    st_next.lpSync = {st_reg.lpSync[0], reducedPowerPin};
    st_next.pdSync = {st_reg.pdSync[0], powerdownPin};
    st_next.chanSync0 = chanSel;
    st_next.chanSync1 = st_reg.chanSync0;
    st_next.gainSync0 = gainSel;
    st_next.gainSync1 = st_reg.gainSync0;
    // The code is delayed like the select line, so it matches the sampling instant.
    st_next.sampleSync0 = sampleCode;
    st_next.sampleSync1 = st_reg.sampleSync0;
    st_next.selPrev = st_reg.selSync[1];
    st_next.sckPrev = st_reg.sckSync[1];
    selFall = isRise(!st_reg.selPrev, !st_reg.selSync[1]);
    selRise = isRise(st_reg.selPrev, st_reg.selSync[1]);
    // The read clock must hold each level longer than one system clock, or edges are lost.
    sckRise = isRise(st_reg.sckPrev, st_reg.sckSync[1]);
    gainForConv = st_reg.lpSync[1] ? st_reg.gainSync1 : st_reg.gainLatched;
    convLimit = (gainForConv == sar_pkg::GainBypassCode) ?
      sar_pkg::CountWidth'(ConvBypassCount) : sar_pkg::CountWidth'(ConvCount);
    st_next.pushValid = 1'b0;
    // The overrun flag is sticky until reset, so a lost word cannot go unseen.
    if (st_reg.pushValid && !bufInReady) begin
      st_next.overrun = 1'b1;
    end
    if (st_reg.pdSync[1]) begin
      st_next.needsWarm = 1'b1;
    end
    if (st_reg.selSync[1]) begin
      st_next.sdoEnN = 1'b1;
      st_next.sdo = 1'b0;
    end
    // A conversion ending in this cycle sets the nap flag again below, so the set wins.
    // full power at select rise; latch gain
    if (selRise) begin
      st_next.idle_partial_powerdown = 1'b0;
      st_next.gainLatched = st_reg.gainSync1;
    end
    unique case (st_reg.phase)
      sar_pkg::SAR_ACQ: begin
        if (selFall && !st_reg.pdSync[1]) begin
          st_next.phase = sar_pkg::SAR_CONV;
          st_next.convCnt = '0;
          st_next.busy = 1'b1;
          st_next.sdoEnN = 1'b0;
          st_next.sdo = 1'b0;
          st_next.shiftReg = {st_reg.sampleSync1, st_reg.chanSync1, gainForConv};
          st_next.curInvalid = st_reg.needsWarm && !st_reg.lpSync[1];
          st_next.needsWarm = 1'b0;
        end
      end
      sar_pkg::SAR_CONV: begin
        // Counting to the limit minus one keeps busy high for exactly limit cycles.
        // busy for timed conversion
        if (st_reg.convCnt >= convLimit - sar_pkg::CountWidth'(1)) begin
          st_next.busy = 1'b0;
          // readout then acquisition; nap after conversion
          st_next.phase = sar_pkg::SAR_READ;
          st_next.idle_partial_powerdown = 1'b1;
          st_next.invalid = st_reg.curInvalid;
          st_next.sdo = st_reg.shiftReg[sar_pkg::FrameBits-1];
          st_next.bitCnt = '0;
          st_next.pushValid = 1'b1;
          st_next.pushData = {st_reg.curInvalid, st_reg.shiftReg};
        end else begin
          st_next.convCnt = st_reg.convCnt + sar_pkg::CountWidth'(1);
        end
      end
      sar_pkg::SAR_READ: begin
        // Edges past the last report bit are refused and the last bit stays on the pin.
        // shift per rising edge, stop at frame end
        if (sckRise && !st_reg.selSync[1] &&
            st_reg.bitCnt < sar_pkg::BitCountWidth'(sar_pkg::FrameBits - 1)) begin
          st_next.shiftReg = {st_reg.shiftReg[sar_pkg::FrameBits-2:0], 1'b0};
          st_next.sdo = st_reg.shiftReg[sar_pkg::FrameBits-2];
          st_next.bitCnt = st_reg.bitCnt + sar_pkg::BitCountWidth'(1);
        end
        if (st_reg.selSync[1]) begin
          st_next.phase = sar_pkg::SAR_ACQ;
        end
      end
      default: begin
        st_next.phase = sar_pkg::SAR_ACQ;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.selSync <= 2'h3;
      st_reg.selPrev <= 1'b1;
      st_reg.sdoEnN <= 1'b1;
      st_reg.needsWarm <= 1'b1;
      st_reg.phase <= sar_pkg::SAR_ACQ;
    end else begin
      st_reg <= st_next;
    end
  end
  // A stalled reader can hold two words; a third is flagged and dropped.
  sar_buf2 #(.Width(21)) u_buf (
    .mclk(mclk),
    .rst(rst),
    .inValid(st_reg.pushValid),
    .inReady(bufInReady),
    .inData(st_reg.pushData),
    .outValid(bufOutValid),
    .outReady(wordReady),
    .outData(bufOutData)
  );
  assign busy = st_reg.busy;
  assign sdoOut = st_reg.sdo;
  assign sdoOutEnN = st_reg.sdoEnN;
  assign idlePartialPowerdown = st_reg.idle_partial_powerdown;
  assign sampleInvalid = st_reg.invalid;
  assign wordOverrun = st_reg.overrun;
  assign wordValid = bufOutValid;
  assign wordData = bufOutData;
endmodule

// ### core/sar_buf2.sv
// Two-entry buffer holding finished conversion words.
// Assumes both sides run on the same clock and reset.
`timescale 1ns/10ps
module sar_buf2 #(
  parameter int Width = 21
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [Width-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [Width-1:0] outData
);
  typedef struct packed {
    logic [1:0][Width-1:0] mem;
    logic wrPtr;
    logic rdPtr;
    logic [1:0] count;
    logic valid;
    logic notFull;
    logic [Width-1:0] head;
  } sar_buf_s;
  sar_buf_s st_reg;
  sar_buf_s st_next;
  logic doWrite;
  logic doRead;
  always_comb begin
    st_next = st_reg;
    doWrite = inValid && (st_reg.count != 2'h2);
    doRead = outReady && (st_reg.count != 2'h0);
    if (doWrite) begin
      st_next.mem[st_reg.wrPtr] = inData;
      st_next.wrPtr = ~st_reg.wrPtr;
    end
    if (doRead) begin
      st_next.rdPtr = ~st_reg.rdPtr;
    end
    if (doWrite && !doRead) begin
      st_next.count = st_reg.count + 2'h1;
    end else if (doRead && !doWrite) begin
      st_next.count = st_reg.count - 2'h1;
    end
    // Flags and head word are registered so that the outputs come straight from flip-flops.
    st_next.valid = (st_next.count != 2'h0);
    st_next.notFull = (st_next.count != 2'h2);
    st_next.head = st_next.mem[st_next.rdPtr];
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.notFull <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
  assign inReady = st_reg.notFull;
  assign outValid = st_reg.valid;
  assign outData = st_reg.head;
endmodule

// ### core/sar_pkg.sv
// Shared constants for the converter sequencing and serial readout block.
// Assumes a 100 MHz system clock; all counts are derived from it here.
package sar_pkg;
  localparam int ClkPeriodNs = 10;
  // Conversion interval with the gain amplifier in use.
  localparam int ConvIntervalNs = 1550;
  // Conversion interval with the gain amplifier bypassed.
  localparam int ConvBypassNs = 660;
  localparam int ConvCycles = ConvIntervalNs / ClkPeriodNs;
  localparam int ConvBypassCycles = ConvBypassNs / ClkPeriodNs;
  // Least high time of the select line, kept by the host; nothing checks it.
  localparam int SelHighNormalNs = 150;
  localparam int SelHighReducedNs = 500;
  localparam int ResultBits = 14;
  localparam int ReportBits = 6;
  localparam int FrameBits = ResultBits + ReportBits;
  localparam int ChanBits = 3;
  localparam int GainBits = 3;
  localparam int CountWidth = 12;
  localparam int BitCountWidth = 5;
  localparam logic [13:0] ResultReset = 14'h0000;
  // The gain code that selects the amplifier bypass.
  localparam logic [2:0] GainBypassCode = 3'h0;
  typedef enum logic [1:0] {
    SAR_ACQ = 2'b00,
    SAR_CONV = 2'b01,
    SAR_READ = 2'b10
  } sar_phase_e;
endpackage
